// >>> src/isc_core.v
// Stop-sequence collision logic and shared serial-clock generator, APB slave.
// Assumes open-drain pins resolved outside; pin inputs synchronous to pclk.
`timescale 1ns/1ps
`include "isc_consts.vh"

// Summary of operation
// - Released data line still low after counter expiry in a stop flags collision.
// - Clock line low after it was seen high, before data released, flags collision.
// - Stop drives data and clock low together, releases clock once data reads low.
// - Released clock seen high (stretching honoured) loads counter and counts down.
// - On expiry during stop, a low data sample means another master: collision.
// - One counter times the stop sequence in bus mode and makes the SPI master serial clock.
// - Writing the shift buffer in SPI mode starts the counter counting down.
// - On completion the counter stops and the clock output holds its level.
// - Counter reloads twice per serial clock period, once per half.
// - Clock rate is oscillator over eight times reload plus one.
// - Any collision sets the collision flag and returns the port to idle.
// - Collision aborts the sequence, releases both lines, clears the request bit.
module isc_core #(
	parameter W = 8
) (
	// APB slave.
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	// Serial lines, open drain.
	input  wire        sda_in,
	output wire        sda_out,
	output wire        sda_oe,
	input  wire        scl_in,
	output wire        scl_out,
	output wire        scl_oe,
	// SPI serial clock.
	output wire        spi_sck,
	// Interrupt.
	output wire        irq
);
	localparam ST_IDLE  = 3'h0;
	localparam ST_SDALO = 3'h1;
	localparam ST_SCLREL= 3'h2;
	localparam ST_SCLHI = 3'h3;
	localparam ST_SDAREL= 3'h4;
	localparam ST_SPI   = 3'h5;

	reg [W-1:0]          reload_r;
	reg [7:0]            shift_r;
	reg [1:0]            ctrl_r;
	reg                  stop_req_r;
	reg [`ISC_EVT_W-1:0] status_r;
	reg [`ISC_EVT_W-1:0] mask_r;
	reg [2:0]            state_r;
	reg [2:0]            state_nxt;
	reg                  sda_drv_r;
	reg                  sda_drv_nxt;
	reg                  scl_drv_r;
	reg                  scl_drv_nxt;
	reg                  sck_r;
	reg                  sck_nxt;
	reg [4:0]            halves_r;
	reg [4:0]            halves_nxt;
	reg                  load;
	reg                  run;
	reg                  coll;
	reg                  done;
	reg                  stop_seen;
	wire                 expired;
	wire                 wr;
	wire                 rd;
	wire                 start_wr;
	wire                 mapped;

	// ****************************************************************
	// APB decode
	// ****************************************************************
	assign pready  = 1'b1;
	assign wr      = psel && penable && pwrite;
	assign rd      = psel && penable && !pwrite;
	assign mapped  = (paddr == `ISC_OFF_RELOAD) || (paddr == `ISC_OFF_SHIFT) ||
	                 (paddr == `ISC_OFF_CTRL) || (paddr == `ISC_OFF_SEQ) ||
	                 (paddr == `ISC_OFF_STATUS) || (paddr == `ISC_OFF_MASK);
	assign pslverr = psel && penable && !mapped;
	assign start_wr = wr && (paddr == `ISC_OFF_SHIFT) && ctrl_r[`ISC_CTRL_EN] &&
	                  (state_r == ST_IDLE);

	always @* begin
		case (paddr)
			`ISC_OFF_RELOAD: prdata = {{(32-W){1'b0}}, reload_r};
			`ISC_OFF_SHIFT:  prdata = {24'h0, shift_r};
			`ISC_OFF_CTRL:   prdata = {30'h0, ctrl_r};
			`ISC_OFF_SEQ:    prdata = {31'h0, stop_req_r};
			`ISC_OFF_STATUS: prdata = {{(32-`ISC_EVT_W){1'b0}}, status_r};
			`ISC_OFF_MASK:   prdata = {{(32-`ISC_EVT_W){1'b0}}, mask_r};
			default:         prdata = 32'h0;
		endcase
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reload_r   <= `ISC_RELOAD_RST;
			shift_r    <= 8'h00;
			ctrl_r     <= 2'h0;
			stop_req_r <= 1'b0;
			status_r   <= {`ISC_EVT_W{1'b0}};
			mask_r     <= {`ISC_EVT_W{1'b0}};
		end else begin
			if (wr && paddr == `ISC_OFF_RELOAD)
				reload_r <= pwdata[W-1:0];
			if (start_wr)
				shift_r <= pwdata[7:0];
			if (wr && paddr == `ISC_OFF_CTRL)
				ctrl_r <= pwdata[1:0];
			if (wr && paddr == `ISC_OFF_MASK)
				mask_r <= pwdata[`ISC_EVT_W-1:0];
			if (coll || done)
				stop_req_r <= 1'b0;
			else if (wr && paddr == `ISC_OFF_SEQ && pwdata[`ISC_SEQ_STOP] &&
			         ctrl_r[`ISC_CTRL_EN] && !ctrl_r[`ISC_CTRL_SPI])
				stop_req_r <= 1'b1;
			status_r <= (rd && paddr == `ISC_OFF_STATUS) ? {`ISC_EVT_W{1'b0}} : status_r;
			if (coll)
				status_r[`ISC_ST_COLL] <= 1'b1;
			if (done)
				status_r[`ISC_ST_DONE] <= 1'b1;
			if (stop_seen)
				status_r[`ISC_ST_STOPDET] <= 1'b1;
		end
	end

	assign irq = |(status_r & mask_r);

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	always @* begin
		state_nxt   = state_r;
		sda_drv_nxt = sda_drv_r;
		scl_drv_nxt = scl_drv_r;
		sck_nxt     = sck_r;
		halves_nxt  = halves_r;
		load        = 1'b0;
		run         = 1'b0;
		coll        = 1'b0;
		done        = 1'b0;
		stop_seen   = 1'b0;
		case (state_r)
			ST_IDLE: begin
				if (start_wr && ctrl_r[`ISC_CTRL_SPI]) begin
					load       = 1'b1;
					halves_nxt = 5'h0;
					state_nxt  = ST_SPI;
				end else if (stop_req_r && !coll) begin
					sda_drv_nxt = 1'b1;
					scl_drv_nxt = 1'b1;
					state_nxt   = ST_SDALO;
				end
			end
			ST_SDALO: begin
				if (!sda_in) begin
					scl_drv_nxt = 1'b0;
					state_nxt   = ST_SCLREL;
				end
			end
			ST_SCLREL: begin
				if (scl_in) begin
					load      = 1'b1;
					state_nxt = ST_SCLHI;
				end
			end
			ST_SCLHI: begin
				run = 1'b1;
				if (!scl_in) begin
					coll = 1'b1;
				end else if (expired) begin
					sda_drv_nxt = 1'b0;
					load        = 1'b1;
					state_nxt   = ST_SDAREL;
				end
			end
			ST_SDAREL: begin
				run = 1'b1;
				if (expired) begin
					if (!sda_in)
						coll = 1'b1;
					else begin
						done      = 1'b1;
						stop_seen = scl_in;
						state_nxt = ST_IDLE;
					end
				end
			end
			ST_SPI: begin
				run = 1'b1;
				if (expired) begin
					sck_nxt    = !sck_r;
					halves_nxt = halves_r + 5'h1;
					if (halves_r == `ISC_HALVES_LAST) begin
						done      = 1'b1;
						state_nxt = ST_IDLE;
					end else
						load = 1'b1;
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
		if (coll) begin
			sda_drv_nxt = 1'b0;
			scl_drv_nxt = 1'b0;
			state_nxt   = ST_IDLE;
		end
		if (!ctrl_r[`ISC_CTRL_EN]) begin
			sda_drv_nxt = 1'b0;
			scl_drv_nxt = 1'b0;
			state_nxt   = ST_IDLE;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r   <= ST_IDLE;
			sda_drv_r <= 1'b0;
			scl_drv_r <= 1'b0;
			sck_r     <= 1'b0;
			halves_r  <= 5'h0;
		end else begin
			state_r   <= state_nxt;
			sda_drv_r <= sda_drv_nxt;
			scl_drv_r <= scl_drv_nxt;
			sck_r     <= sck_nxt;
			halves_r  <= halves_nxt;
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe  = sda_drv_r;
	assign scl_out = 1'b0;
	assign scl_oe  = scl_drv_r;
	assign spi_sck = sck_r;

	// ****************************************************************
	// Bit-rate counter
	// ****************************************************************
	isc_brg #(
		.W (W)
	) u_brg (
		.pclk    (pclk),
		.presetn (presetn),
		.load    (load),
		.run     (run),
		.reload  (reload_r),
		.expired (expired)
	);
endmodule // isc_core

// >>> src/isc_consts.vh
// Constants for the stop-collision and bit-rate generator block.
// Assumes a 32-bit APB register bus and a 100 MHz pclk.
`ifndef ISC_CONSTS_VH
`define ISC_CONSTS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define ISC_OFF_RELOAD   12'h000
`define ISC_OFF_SHIFT    12'h004
`define ISC_OFF_CTRL     12'h008
`define ISC_OFF_SEQ      12'h00C
`define ISC_OFF_STATUS   12'h010
`define ISC_OFF_MASK     12'h014

// ****************************************************************
// Field positions
// ****************************************************************
`define ISC_CTRL_EN      0
`define ISC_CTRL_SPI     1
`define ISC_SEQ_STOP     0
`define ISC_ST_COLL      0
`define ISC_ST_DONE      1
`define ISC_ST_STOPDET   2
`define ISC_EVT_W        3

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define ISC_RELOAD_RST   8'h13
`define ISC_PRE_LAST     2'h3
`define ISC_SPI_BITS     4'h8
`define ISC_HALVES_LAST  5'h0F

`endif

// >>> src/isc_brg.v
// Bit-rate down-counter with a quarter-rate prescaler.
// Assumes reload and start pulses synchronous to pclk.
`timescale 1ns/1ps

module isc_brg #(
	parameter W = 8
) (
	// Clock and reset.
	input  wire         pclk,
	input  wire         presetn,
	// Control.
	input  wire         load,
	input  wire         run,
	input  wire [W-1:0] reload,
	// Status.
	output wire         expired
);
	reg [1:0]   pre_r;
	reg [W-1:0] cnt_r;

	// ****************************************************************
	// Counter
	// ****************************************************************
	assign expired = run && (cnt_r == {W{1'b0}}) && (pre_r == `ISC_PRE_LAST);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_r <= 2'h0;
			cnt_r <= {W{1'b0}};
		end else if (load) begin
			pre_r <= 2'h0;
			cnt_r <= reload;
		end else if (run) begin
			pre_r <= pre_r + 2'h1;
			if (pre_r == `ISC_PRE_LAST && cnt_r != {W{1'b0}})
				cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
		end
	end
endmodule // isc_brg

// >>> sim/isc_checker.sv
// Concurrent checks on the ports of isc_core.
// Assumes a bind onto isc_core; sees only its ports.
`timescale 1ns/1ps
module isc_checker (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire        sda_in,
	input wire        sda_out,
	input wire        sda_oe,
	input wire        scl_in,
	input wire        scl_out,
	input wire        scl_oe,
	input wire        spi_sck,
	input wire        irq
);
	reg  [7:0]  rld_r;
	reg  [10:0] gap_r;
	reg         armed_r;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Track the reload value and the spacing of clock toggles.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rld_r <= 8'h13;
			gap_r <= 11'h000;
			armed_r <= 1'b0;
		end else begin
			gap_r <= $changed(spi_sck) ? 11'h001 : gap_r + 11'h001;
			if (psel && penable && pwrite && paddr == 12'h000)
				rld_r <= pwdata[7:0];
			if (psel && penable && pwrite && paddr[11:3] == 9'h000)
				armed_r <= 1'b0;
			else if ($changed(spi_sck))
				armed_r <= 1'b1;
		end
	end
	a_zero_wait: assert property (psel |-> pready) else $error("pready low");
	a_unmapped_err: assert property (psel && penable && paddr > 12'h014 |-> pslverr)
		else $error("no error on unmapped access");
	a_upper_zero: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h000000)
		else $error("upper read bits set");
	a_pins_low: assert property (!sda_out && !scl_out) else $error("pin driven high");
	a_data_first: assert property ($rose(scl_oe) |-> sda_oe) else $error("clock before data");
	a_clk_release: assert property ($fell(scl_oe) && sda_oe |-> !sda_in)
		else $error("clock released before data low");
	a_stop_clash: assert property (sda_oe && !scl_oe && $fell(scl_in) |-> ##[0:4] (!sda_oe && !scl_oe))
		else $error("clock collision not handled");
	a_reset_idle: assert property ($rose(presetn) |-> !sda_oe && !scl_oe && !irq)
		else $error("not idle after reset");
	a_half_period: assert property ($changed(spi_sck) && armed_r |-> gap_r == {1'b0, rld_r, 2'b00} + 11'h004)
		else $error("wrong half period");
	c_clash: cover property (sda_oe && !scl_oe && $fell(scl_in));
	c_release: cover property ($fell(sda_oe) && !scl_oe);
	c_toggle: cover property ($changed(spi_sck) && armed_r);
endmodule // isc_checker
bind isc_core isc_checker u_isc_checker (.*);

// >>> sim/isc_bus_peer.sv
// Other masters and slaves sharing the open-drain lines.
// Assumes pull-ups on both lines; the bench commands each pull-down.
`timescale 1ns/1ps
module isc_bus_peer (
	input  wire sda_oe,
	input  wire sda_out,
	input  wire scl_oe,
	input  wire scl_out,
	input  wire hold_sda,
	input  wire hold_scl,
	output wire sda_in,
	output wire scl_in
);
	// A released line floats high unless the peer pulls it or stretches it.
	assign sda_in = !hold_sda && (sda_oe ? sda_out : 1'b1);
	assign scl_in = !hold_scl && (scl_oe ? scl_out : 1'b1);
endmodule // isc_bus_peer

// >>> sim/tb_top.sv
// Self-checking bench for isc_core over APB with a bus peer.
// Assumes isc_core, isc_bus_peer and the checker are compiled first.
`timescale 1ns/1ps
`include "isc_consts.vh"
module tb_top;
	reg         pclk = 1'b0;
	reg         presetn = 1'b0;
	reg         psel = 1'b0;
	reg         penable = 1'b0;
	reg         pwrite = 1'b0;
	reg  [11:0] paddr = 12'h000;
	reg  [31:0] pwdata = 32'h0;
	reg         hold_sda = 1'b0;
	reg         hold_scl = 1'b0;
	reg  [31:0] q;
	reg         qe;
	wire [31:0] prdata;
	wire        pready, pslverr, sda_in, sda_out, sda_oe, scl_in, scl_out, scl_oe, spi_sck, irq;
	integer     num_errors = 0;
	integer     num_checks = 0;
	integer     tog = 0;
	integer     n;
	integer     m;
	always #5 pclk = ~pclk;
	always @(spi_sck) tog = tog + 1;
	isc_core u_isc_core (.*);
	isc_bus_peer u_isc_bus_peer (.*);
	task chk(input [31:0] s, input [31:0] e);
		begin
			num_checks = num_checks + 1;
			if (s !== e) begin
				num_errors = num_errors + 1;
				$display("BAD %0t seen %h expected %h", $time, s, e);
			end
		end
	endtask
	task apb(input [11:0] a, input w, input [31:0] d);
		begin
			@(posedge pclk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			do
				@(posedge pclk);
			while (pready !== 1'b1);
			q = prdata;
			qe = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task rd(input [11:0] a, input [31:0] e);
		begin
			apb(a, 1'b0, 32'h0);
			chk(q, e);
		end
	endtask
	task run_stop(input [31:0] e);
		begin
			apb(`ISC_OFF_SEQ, 1'b1, 32'h1);
			repeat (2) @(negedge pclk);
			for (n = 0; n < 500 && (sda_oe || scl_oe); n = n + 1)
				@(negedge pclk);
			repeat (40) @(negedge pclk);
			chk(irq, 32'h1);
			rd(`ISC_OFF_STATUS, e);
			@(negedge pclk);
			chk(irq, 32'h0);
			rd(`ISC_OFF_SEQ, 32'h0);
		end
	endtask
	task close_out;
		begin
			if (num_errors == 0 && num_checks > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	initial begin
		#100000;
		num_errors = num_errors + 1;
		close_out;
	end
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd(`ISC_OFF_RELOAD, 32'h13);
		chk(qe, 32'h0);
		rd(12'h020, 32'h0);
		chk(qe, 32'h1);
		apb(`ISC_OFF_RELOAD, 1'b1, 32'h3);
		apb(`ISC_OFF_MASK, 1'b1, 32'h7);
		rd(`ISC_OFF_MASK, 32'h7);
		apb(`ISC_OFF_CTRL, 1'b1, 32'h1);
		hold_scl <= 1'b1;
		fork
			run_stop(32'h6);
			begin
				wait (scl_oe);
				wait (!scl_oe);
				repeat (30) @(negedge pclk);
				chk(sda_oe, 32'h1);
				@(posedge pclk);
				hold_scl <= 1'b0;
				for (m = 0; m < 100 && sda_oe; m = m + 1)
					@(negedge pclk);
				chk(m >= 16 && m <= 20, 32'h1);
			end
		join
		@(posedge pclk);
		hold_sda <= 1'b1;
		run_stop(32'h1);
		@(posedge pclk);
		hold_sda <= 1'b0;
		fork
			run_stop(32'h1);
			begin
				wait (scl_oe);
				wait (!scl_oe);
				repeat (6) @(posedge pclk);
				hold_scl <= 1'b1;
			end
		join
		@(posedge pclk);
		hold_scl <= 1'b0;
		apb(`ISC_OFF_MASK, 1'b1, 32'h0);
		apb(`ISC_OFF_CTRL, 1'b1, 32'h3);
		apb(`ISC_OFF_SEQ, 1'b1, 32'h1);
		tog = 0;
		repeat (40) @(negedge pclk);
		chk(sda_oe, 32'h0);
		chk(tog, 32'h0);
		apb(`ISC_OFF_SHIFT, 1'b1, 32'hA5);
		repeat (320) @(negedge pclk);
		chk(tog, 32'h10);
		chk(spi_sck, 32'h0);
		chk(irq, 32'h0);
		rd(`ISC_OFF_STATUS, 32'h2);
		close_out;
	end
endmodule // tb_top
